// file: osc_pkg.sv
// Package for the oscillator select and divider control block.
// Assumes an APB slave with 32-bit data, one register per aligned word.
`default_nettype none

package osc_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] OSC_CTRL_ADDR = 12'h000;
  localparam logic [11:0] CLK_DIV_ADDR = 12'h004;

  // ----------------------------------------------------------------------
  // Oscillator control fields
  // ----------------------------------------------------------------------
  localparam int CUR_SRC_LSB = 12;
  localparam int NEW_SRC_LSB = 8;
  localparam int SEL_LOCK_BIT = 7;
  localparam int PIN_LOCK_BIT = 6;
  localparam int PLL_LOCK_BIT = 5;
  localparam int FAIL_BIT = 3;
  localparam int PRI_SLEEP_BIT = 2;
  localparam int SEC_EN_BIT = 1;
  localparam int SWITCH_BIT = 0;

  // ----------------------------------------------------------------------
  // Clock divider fields
  // ----------------------------------------------------------------------
  localparam int RECOVER_BIT = 15;
  localparam int RATIO_LSB = 12;
  localparam int RATIO_EN_BIT = 11;
  localparam int RC_DIV_LSB = 8;
  localparam int SYS_DIV_LSB = 6;
  localparam logic [2:0] RC_DIV_RESET = 3'h1;

  // ----------------------------------------------------------------------
  // Source codes and timing
  // ----------------------------------------------------------------------
  localparam logic [2:0] SRC_FAST_RC_DIV = 3'h7;
  localparam logic [2:0] SRC_PRI_PLL = 3'h3;
  localparam logic [2:0] SRC_FAST_RC_PLL = 3'h1;
  localparam logic [3:0] SETTLE_CYCLES = 4'hA;

  typedef enum logic [1:0] {
    OSC_IDLE,
    OSC_SETTLE,
    OSC_DONE
  } osc_sw_state_e;

  typedef struct packed {
    logic [1:0] switch_monitor_config;
    logic [1:0] primary_mode_config;
    logic [2:0] initial_source_config;
    logic pin_map_one_way_config;
  } osc_config_s;

endpackage

`default_nettype wire

// file: osc_ctrl.sv
// Oscillator source selection and clock divider control, APB slave.
// Assumes config bits and oscillator status are stable or come from pins.
// Functional notes
// RULE1: switching allowed only when switch enable config bit is zero
// RULE2: fail-safe monitor enabled only when both config bits are zero
// RULE3: power-on source comes from primary mode and initial source config; code uses initial source config only
// RULE4: unprogrammed device starts on fast RC with postscaler, code 111
// RULE5: current source field, read only, bits 14-12, hardware updated
// RULE6: writable new source field at bits 10-8 targets next switch
// RULE7: reset loads current and new source from initial source config
// RULE8: monitor enabled and lock bit set blocks switch requests
// RULE9: pin lock changes only after unlock; one-way config prevents clearing
// RULE10: PLL lock status reads one when locked or start timer expired; code has no start timer, shows synced lock pin only
// RULE11: PLL lock reads zero on valid switch or non-PLL mode
// RULE12: clock fail flag set by monitor, reset zero, software clears
// RULE13: primary oscillator runs in sleep only when sleep enable set
// RULE14: secondary oscillator enabled while secondary enable bit is one
// RULE15: writing switch request starts switch; reads zero when complete
// RULE16: recover on interrupt clears ratio enable on any interrupt
// RULE17: ratio field decodes powers of two, 1:1 up to 1:128
// RULE18: ratio applies only while ratio enable is one, else 1:1
// RULE19: fast RC postscaler divides by 1..64, code 111 by 256
// RULE20: system clock postscaler divides 32 MHz branch by 1,2,4,8
// RULE21: software avoids divide by 4 or 8 while USB enabled
// RULE22: switch with new equal current is redundant, cleared and aborted
// RULE23: wait ten new-source clock cycles before changing over
// RULE24: on completion copy new source to current, clear request
// RULE25: switching disabled holds switch request at zero
// RULE26: lock bit set by software write of one, cleared by reset
// RULE27: divider resets with postscaler 001, other fields zero
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module osc_ctrl #(
  // Rising edges of the new source counted before change-over
  parameter int SETTLE_COUNT = int'(osc_pkg::SETTLE_CYCLES)
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Configuration, unlock and events
  input wire osc_pkg::osc_config_s cfg,
  input wire logic unlock_ok,
  input wire logic irq_any,
  input wire logic sleep_mode,
  input wire logic usb_enabled,
  // Oscillator status from pins or other clocks
  input wire logic pll_locked_pin,
  input wire logic clock_fail_pin,
  input wire logic new_src_tick_pin,
  // Clock control outputs
  output logic [2:0] sys_source,
  output logic primary_run,
  output logic secondary_run,
  output logic [7:0] periph_ratio,
  output logic [8:0] rc_divisor,
  output logic [3:0] sys_divisor,
  output logic pin_map_locked,
  output logic switch_busy
);

  // The settle counter is four bits wide
  if (SETTLE_COUNT < 1 || SETTLE_COUNT > 15) begin : g_settle_check
    $error("settle count must lie between 1 and 15");
  end

  // ----------------------------------------------------------------------
  // Synchronisers for asynchronous status
  // ----------------------------------------------------------------------
  logic [2:0] meta_r;
  logic [2:0] sync_r;
  logic tick_prev_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 3'h0;
      sync_r <= 3'h0;
      tick_prev_r <= 1'b0;
    end else begin
      meta_r <= {new_src_tick_pin, clock_fail_pin, pll_locked_pin};
      sync_r <= meta_r;
      tick_prev_r <= sync_r[2];
    end
  end
  wire logic pll_locked = sync_r[0];
  wire logic clock_fail = sync_r[1];
  wire logic new_tick = sync_r[2] & ~tick_prev_r;

  // ----------------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------------
  wire logic switch_ok = ~cfg.switch_monitor_config[1]; // RULE1
  wire logic monitor_on = (cfg.switch_monitor_config == 2'h0); // RULE2

  // Strap capture after reset release
  logic strap_done_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_done_r <= 1'b0;
    end else begin
      strap_done_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  wire logic acc = psel & penable;
  wire logic wr = acc & pwrite;
  wire logic hit_osc = (paddr == osc_pkg::OSC_CTRL_ADDR);
  wire logic hit_div = (paddr == osc_pkg::CLK_DIV_ADDR);
  wire logic wr_osc = wr & hit_osc;
  wire logic wr_div = wr & hit_div;
  assign pready = 1'b1;
  assign pslverr = acc & ~(hit_osc | hit_div);

  // ----------------------------------------------------------------------
  // Oscillator control register
  // ----------------------------------------------------------------------
  logic [2:0] cur_src_r;
  logic [2:0] new_src_r;
  logic sel_lock_r;
  logic pin_lock_r;
  logic fail_r;
  logic pri_sleep_r;
  logic sec_en_r;
  logic switch_r;
  logic pll_stat_r;
  osc_pkg::osc_sw_state_e state_r;
  logic [3:0] settle_r;

  wire logic locked = monitor_on & sel_lock_r; // RULE8
  wire logic wr_switch = wr_osc & pwdata[osc_pkg::SWITCH_BIT];
  wire logic start_req = wr_switch & switch_ok & ~locked & (state_r == osc_pkg::OSC_IDLE);
  wire logic redundant = (new_src_r == cur_src_r);
  wire logic cur_pll = (cur_src_r == osc_pkg::SRC_PRI_PLL)
    | (cur_src_r == osc_pkg::SRC_FAST_RC_PLL);
  wire logic pin_lock_nxt = (~pin_lock_r | ~cfg.pin_map_one_way_config)
    ? pwdata[osc_pkg::PIN_LOCK_BIT] : 1'b1; // RULE9

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_src_r <= osc_pkg::SRC_FAST_RC_DIV;
      new_src_r <= osc_pkg::SRC_FAST_RC_DIV;
      state_r <= osc_pkg::OSC_IDLE;
      settle_r <= 4'h0;
      switch_r <= 1'b0;
    end else if (!strap_done_r) begin
      cur_src_r <= cfg.initial_source_config; // RULE7 RULE3 RULE4
      new_src_r <= cfg.initial_source_config; // RULE7
    end else begin
      if (wr_osc && !locked && state_r == osc_pkg::OSC_IDLE) begin
        new_src_r <= pwdata[osc_pkg::NEW_SRC_LSB +: 3]; // RULE6
      end
      case (state_r)
        osc_pkg::OSC_IDLE: begin
          if (start_req) begin
            switch_r <= 1'b1; // RULE15 RULE25
            state_r <= osc_pkg::OSC_SETTLE;
            settle_r <= 4'h0;
          end
        end
        osc_pkg::OSC_SETTLE: begin
          if (redundant) begin
            switch_r <= 1'b0; // RULE22
            state_r <= osc_pkg::OSC_IDLE;
          end else if (new_tick) begin
            settle_r <= settle_r + 4'h1;
            if (settle_r == 4'(SETTLE_COUNT - 1)) begin
              state_r <= osc_pkg::OSC_DONE; // RULE23
            end
          end
        end
        osc_pkg::OSC_DONE: begin
          cur_src_r <= new_src_r; // RULE24 RULE5
          switch_r <= 1'b0; // RULE24
          state_r <= osc_pkg::OSC_IDLE;
        end
        default: state_r <= osc_pkg::OSC_IDLE;
      endcase
    end
  end

  wire logic valid_start = (state_r == osc_pkg::OSC_SETTLE) & ~redundant & (settle_r == 4'h0)
    & ~new_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_lock_r <= 1'b0;
      pin_lock_r <= 1'b0;
      fail_r <= 1'b0;
      pri_sleep_r <= 1'b0;
      sec_en_r <= 1'b0;
      pll_stat_r <= 1'b0;
    end else begin
      if (wr_osc && pwdata[osc_pkg::SEL_LOCK_BIT]) begin
        sel_lock_r <= 1'b1; // RULE26
      end
      if (wr_osc && unlock_ok) begin
        pin_lock_r <= pin_lock_nxt; // RULE9
      end
      if (monitor_on && clock_fail) begin
        fail_r <= 1'b1; // RULE12
      end else if (valid_start || (wr_osc && !pwdata[osc_pkg::FAIL_BIT])) begin
        fail_r <= 1'b0; // RULE12
      end
      if (wr_osc) begin
        pri_sleep_r <= pwdata[osc_pkg::PRI_SLEEP_BIT];
        sec_en_r <= pwdata[osc_pkg::SEC_EN_BIT];
      end
      pll_stat_r <= cur_pll & pll_locked & ~valid_start & ~switch_r; // RULE10 RULE11
    end
  end

  // ----------------------------------------------------------------------
  // Clock divider register
  // ----------------------------------------------------------------------
  logic recover_r;
  logic [2:0] ratio_r;
  logic ratio_en_r;
  logic [2:0] rc_div_r;
  logic [1:0] sys_div_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      recover_r <= 1'b0;
      ratio_r <= 3'h0;
      ratio_en_r <= 1'b0;
      rc_div_r <= osc_pkg::RC_DIV_RESET; // RULE27
      sys_div_r <= 2'h0;
    end else begin
      if (wr_div) begin
        recover_r <= pwdata[osc_pkg::RECOVER_BIT];
        ratio_r <= pwdata[osc_pkg::RATIO_LSB +: 3];
        rc_div_r <= pwdata[osc_pkg::RC_DIV_LSB +: 3];
        sys_div_r <= pwdata[osc_pkg::SYS_DIV_LSB +: 2]; // RULE21
      end
      if (recover_r && irq_any) begin
        ratio_en_r <= 1'b0; // RULE16
      end else if (wr_div) begin
        ratio_en_r <= pwdata[osc_pkg::RATIO_EN_BIT];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Clock control outputs
  // ----------------------------------------------------------------------
  logic [7:0] ratio_q;
  logic [8:0] rc_q;
  logic [3:0] sys_q;
  logic [2:0] src_q;
  logic pri_q;
  logic sec_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ratio_q <= 8'h01;
      rc_q <= 9'h002;
      sys_q <= 4'h1;
      src_q <= osc_pkg::SRC_FAST_RC_DIV;
      pri_q <= 1'b0;
      sec_q <= 1'b0;
    end else begin
      ratio_q <= ratio_en_r ? (8'h01 << ratio_r) : 8'h01; // RULE17 RULE18
      rc_q <= (rc_div_r == 3'h7) ? 9'h100 : (9'h001 << rc_div_r); // RULE19
      sys_q <= 4'h1 << sys_div_r; // RULE20
      src_q <= cur_src_r;
      pri_q <= ~sleep_mode | pri_sleep_r; // RULE13
      sec_q <= sec_en_r; // RULE14
    end
  end
  assign periph_ratio = ratio_q;
  assign rc_divisor = rc_q;
  assign sys_divisor = sys_q;
  assign sys_source = src_q;
  assign primary_run = pri_q;
  assign secondary_run = sec_q;
  assign pin_map_locked = pin_lock_r;
  assign switch_busy = switch_r;

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  wire logic [15:0] osc_rd = {1'b0, cur_src_r, 1'b0, new_src_r, sel_lock_r, pin_lock_r,
    pll_stat_r, 1'b0, fail_r, pri_sleep_r, sec_en_r, switch_r};
  wire logic [15:0] div_rd = {recover_r, ratio_r, ratio_en_r, rc_div_r, sys_div_r, 6'h00};
  logic [31:0] rd_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_r <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      rd_r <= hit_osc ? {16'h0, osc_rd} : (hit_div ? {16'h0, div_rd} : 32'h0);
    end
  end
  assign prdata = rd_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  switch_disabled_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE25
    !switch_ok |-> !switch_r)
    else $error("switch request set while switching disabled");
  switch_start_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
    start_req |=> switch_r && state_r == osc_pkg::OSC_SETTLE)
    else $error("switch request not started");
  settle_count_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE23
    (state_r == osc_pkg::OSC_DONE)
      |-> $past(new_tick) && $past(settle_r) == 4'(SETTLE_COUNT - 1))
    else $error("switch completed before settle count");
  cur_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    (strap_done_r && state_r != osc_pkg::OSC_DONE) |=> cur_src_r == $past(cur_src_r))
    else $error("current source changed outside completion");
  pll_shown_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    (cur_pll && pll_locked && state_r == osc_pkg::OSC_IDLE && !switch_r) |=> pll_stat_r)
    else $error("PLL lock not shown");
  fail_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    (wr_osc && !pwdata[osc_pkg::FAIL_BIT] && !(monitor_on && clock_fail)) |=> !fail_r)
    else $error("clock fail flag not cleared");
  sel_lock_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE26
    sel_lock_r |=> sel_lock_r)
    else $error("selection lock cleared without reset");
  pin_unlock_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    !unlock_ok |=> pin_lock_r == $past(pin_lock_r))
    else $error("pin map lock changed without unlock");
  lock_blocks_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    (locked && state_r == osc_pkg::OSC_IDLE && !switch_r) |=> !switch_r)
    else $error("switch started while selection locked");
  redundant_abort_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE22
    (state_r == osc_pkg::OSC_SETTLE && redundant) |=> !switch_r && cur_src_r == $past(cur_src_r))
    else $error("redundant switch not aborted");
  switch_done_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE24
    (state_r == osc_pkg::OSC_DONE) |=> !switch_r && cur_src_r == $past(new_src_r))
    else $error("switch completion wrong");
  ratio_off_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE18
    !ratio_en_r |=> periph_ratio == 8'h01)
    else $error("ratio applied while disabled");
  recover_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
    (recover_r && irq_any) |=> !ratio_en_r ##1 periph_ratio == 8'h01)
    else $error("interrupt did not end doze");
  fail_set_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    (monitor_on && clock_fail) |=> fail_r)
    else $error("clock fail not flagged");
  pll_nonpll_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
    (!cur_pll || switch_r) |=> !pll_stat_r)
    else $error("PLL lock shown in non PLL mode");
  one_way_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    (pin_lock_r && cfg.pin_map_one_way_config) |=> pin_lock_r)
    else $error("pin map lock cleared in one-way mode");

endmodule // osc_ctrl

`default_nettype wire

// file: osc_ctrl_tb.sv
// Self-checking bench for the oscillator select and divider control block.
// Assumes the APB slave answers with pready and that status pins are synced.
`timescale 1ns/1ns
`default_nettype none

module osc_ctrl_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  osc_pkg::osc_config_s cfg;
  logic unlock_ok, irq_any, sleep_mode, usb_enabled;
  logic pll_locked_pin, clock_fail_pin, new_src_tick_pin;
  logic [2:0] sys_source;
  logic primary_run, secondary_run, pin_map_locked, switch_busy, err_bit;
  logic [7:0] periph_ratio;
  logic [8:0] rc_divisor;
  logic [3:0] sys_divisor;
  int err_count, n_compared;

  osc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cfg(cfg), .unlock_ok(unlock_ok), .irq_any(irq_any),
    .sleep_mode(sleep_mode), .usb_enabled(usb_enabled), .pll_locked_pin(pll_locked_pin),
    .clock_fail_pin(clock_fail_pin), .new_src_tick_pin(new_src_tick_pin),
    .sys_source(sys_source), .primary_run(primary_run), .secondary_run(secondary_run),
    .periph_ratio(periph_ratio), .rc_divisor(rc_divisor), .sys_divisor(sys_divisor),
    .pin_map_locked(pin_map_locked), .switch_busy(switch_busy));

  // ----------------------------------------------------------------------
  // Clock, watchdog and verdict
  // ----------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    end_sim();
  end

  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  // ----------------------------------------------------------------------
  // Bus and stimulus tasks
  // ----------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err_bit = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr_osc(input logic [31:0] d);
    apb(1'b1, osc_pkg::OSC_CTRL_ADDR, d);
    cyc(3);
  endtask

  task automatic wr_div(input logic [31:0] d);
    apb(1'b1, osc_pkg::CLK_DIV_ADDR, d);
    cyc(3);
  endtask

  task automatic do_reset(input osc_pkg::osc_config_s c);
    cfg <= c;
    presetn <= 1'b0;
    cyc(4);
    presetn <= 1'b1;
    cyc(3);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      new_src_tick_pin <= 1'b1;
      cyc(4);
      new_src_tick_pin <= 1'b0;
      cyc(4);
    end
  endtask

  task automatic pulse_fail();
    clock_fail_pin <= 1'b1;
    cyc(3);
    clock_fail_pin <= 1'b0;
    cyc(5);
  endtask

  task automatic pulse_irq();
    irq_any <= 1'b1;
    @(posedge pclk);
    irq_any <= 1'b0;
    cyc(4);
  endtask

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    int w;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    cfg = '{2'h3, 2'h3, 3'h7, 1'b1};
    unlock_ok = 1'b0;
    irq_any = 1'b0;
    sleep_mode = 1'b0;
    usb_enabled = 1'b0;
    pll_locked_pin = 1'b0;
    clock_fail_pin = 1'b0;
    new_src_tick_pin = 1'b0;
    err_count = 0;
    n_compared = 0;
    // Unprogrammed configuration: switching and monitor off
    do_reset('{2'h3, 2'h3, 3'h7, 1'b1});
    apb(1'b0, osc_pkg::OSC_CTRL_ADDR, 32'h0);
    chk("osc reset", rd, 32'h0000_7700);
    chk("source", 32'(sys_source), 32'h7);
    apb(1'b0, osc_pkg::CLK_DIV_ADDR, 32'h0);
    chk("div reset", rd, 32'h0000_0100);
    chk("rc divisor", 32'(rc_divisor), 32'h2);
    wr_osc(32'h0000_0001);
    chk("busy disabled", 32'(switch_busy), 32'h0);
    pulse_fail();
    apb(1'b0, osc_pkg::OSC_CTRL_ADDR, 32'h0);
    chk("no switch", rd & 32'h0000_7009, 32'h0000_7000);
    // Programmed: primary with PLL, monitor on, one-way pin lock
    pll_locked_pin <= 1'b1;
    do_reset('{2'h0, 2'h1, 3'h3, 1'b1});
    cyc(3);
    apb(1'b0, osc_pkg::OSC_CTRL_ADDR, 32'h0);
    chk("osc reset pll", rd, 32'h0000_3320);
    chk("source pll", 32'(sys_source), 32'h3);
    for (int i = 0; i < 8; i++) begin
      wr_div(32'((i << 12) | (1 << 11) | (i << 8) | ((i & 3) << 6)));
      chk("ratio", 32'(periph_ratio), 32'(1 << i));
      chk("rc div", 32'(rc_divisor), (i == 7) ? 32'd256 : 32'(1 << i));
      chk("sys div", 32'(sys_divisor), 32'(1 << (i & 3)));
      apb(1'b0, osc_pkg::CLK_DIV_ADDR, 32'h0);
      chk("div read", rd, 32'((i << 12) | (1 << 11) | (i << 8) | ((i & 3) << 6)));
    end
    wr_div(32'h0000_7000);
    chk("ratio off", 32'(periph_ratio), 32'h1);
    wr_div(32'h0000_B800);
    pulse_irq();
    chk("recover ratio", 32'(periph_ratio), 32'h1);
    apb(1'b0, osc_pkg::CLK_DIV_ADDR, 32'h0);
    chk("recover read", rd, 32'h0000_B000);
    wr_div(32'h0000_3800);
    pulse_irq();
    chk("no recover", 32'(periph_ratio), 32'h8);
    // Redundant then valid switch
    wr_osc(32'h0000_0301);
    chk("redundant", 32'(switch_busy), 32'h0);
    chk("src kept", 32'(sys_source), 32'h3);
    wr_osc(32'h0000_0001);
    chk("busy", 32'(switch_busy), 32'h1);
    apb(1'b0, osc_pkg::OSC_CTRL_ADDR, 32'h0);
    chk("lock cleared", rd & 32'h0000_0029, 32'h0000_0001);
    ticks(9);
    chk("still busy", 32'(switch_busy), 32'h1);
    ticks(1);
    w = 0;
    while (switch_busy !== 1'b0 && w < 40) begin
      @(posedge pclk);
      w++;
    end
    cyc(1);
    chk("switched", 32'(sys_source), 32'h0);
    apb(1'b0, osc_pkg::OSC_CTRL_ADDR, 32'h0);
    chk("after switch", rd, 32'h0000_0000);
    // Fail flag, sleep and secondary enables
    pulse_fail();
    apb(1'b0, osc_pkg::OSC_CTRL_ADDR, 32'h0);
    chk("fail set", rd, 32'h0000_0008);
    wr_osc(32'h0000_0006);
    sleep_mode <= 1'b1;
    cyc(3);
    chk("pri sleep on", 32'(primary_run), 32'h1);
    chk("sec on", 32'(secondary_run), 32'h1);
    apb(1'b0, osc_pkg::OSC_CTRL_ADDR, 32'h0);
    chk("fail clear", rd, 32'h0000_0006);
    wr_osc(32'h0000_0000);
    chk("pri sleep off", 32'(primary_run), 32'h0);
    chk("sec off", 32'(secondary_run), 32'h0);
    sleep_mode <= 1'b0;
    // Pin map lock
    wr_osc(32'h0000_0040);
    chk("pin no unlock", 32'(pin_map_locked), 32'h0);
    unlock_ok <= 1'b1;
    wr_osc(32'h0000_0040);
    chk("pin set", 32'(pin_map_locked), 32'h1);
    wr_osc(32'h0000_0000);
    chk("pin one way", 32'(pin_map_locked), 32'h1);
    unlock_ok <= 1'b0;
    // Selection lock blocks switching
    wr_osc(32'h0000_0080);
    wr_osc(32'h0000_0381);
    chk("locked busy", 32'(switch_busy), 32'h0);
    apb(1'b0, osc_pkg::OSC_CTRL_ADDR, 32'h0);
    chk("locked read", rd & 32'h0000_7781, 32'h0000_0080);
    // Unmapped address
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped err", 32'(err_bit), 32'h1);
    chk("unmapped data", rd, 32'h0);
    chk("ready", 32'(pready), 32'h1);
    end_sim();
  end
endmodule // osc_ctrl_tb

`default_nettype wire
